// ==== src/pmu_cfg.svh ====
// pmu_cfg.svh: offsets, field positions, reset values and timing figures of the
// two-wire register port and the interrupt control of the power management unit.
// Assumes that it is included by its bare name wherever a constant is needed.
// How it works
// - Slave only, bus up to 400 kbps.
// - Address 1001001 if select high, else 1001000.
// - Bytes MSB first, each acknowledged by receiver.
// - Start and stop framed while clock high.
// - Direction bit one reads, zero writes.
// - First byte is register index, then data.
// - Read needs repeated start, then device returns data.
// - Interrupt pin is an active-low output.
// - Five sources: alarm, button, power, boost, buck.
// - Per-source mask bits plus one global enable.
// - Enable write sets only bits written one.
// - Disable write clears ones; mask readable separately.
// - Interrupt mask is all zero after reset.
// - Mask bit7 global, bit0 alarm, bit2 power.
// - Pin low only if global and source enabled.
// - Cause status per source; reading it releases pin.
// - Button flags: bit0 seen low, bit1 seen high.
// - Button clear write of one clears that flag.
// - Button enable write sets enables; mask readable.
// - Button disable write clears; zeros do nothing.
// - Readback shows address and alternate flag bit7.
// - Pin low after pull-up selects two-wire port.
`ifndef PMU_CFG_SVH
`define PMU_CFG_SVH
`define PMU_CLK_MHZ            250
`define PMU_SELECT_SETTLE_NS   1000
`define PMU_ADDR_DEFAULT       7'h49
`define PMU_ADDR_ALTERNATE     7'h48
`define PMU_IDX_ADDR_READBACK  8'h01
`define PMU_IDX_BT_STATUS      8'h02
`define PMU_IDX_BT_CLEAR       8'h03
`define PMU_IDX_BT_ENABLE      8'h04
`define PMU_IDX_BT_DISABLE     8'h05
`define PMU_IDX_BT_MASK        8'h06
`define PMU_IDX_IRQ_ENABLE     8'h08
`define PMU_IDX_IRQ_DISABLE    8'h09
`define PMU_IDX_IRQ_MASK_VIEW  8'h0a
`define PMU_IDX_IRQ_CAUSE      8'h0b
`define PMU_IRQ_BIT_GLOBAL     7
`define PMU_BT_BIT_LOW         0
`define PMU_BT_BIT_HIGH        1
`define PMU_IRQ_MASK_RESET     8'h00
`define PMU_BT_RESET           2'h0
`endif

// ==== src/pmu_pkg.sv ====
// pmu_pkg.sv: types shared by the register port and interrupt control.
// Assumes nothing of its surroundings.
package pmu_pkg;
  // Byte-level states of the two-wire slave.
  typedef enum logic [2:0] {
    L_IDLE    = 3'b000,
    L_ADDR    = 3'b001,
    L_ADDR_AK = 3'b010,
    L_RX      = 3'b011,
    L_RX_AK   = 3'b100,
    L_TX      = 3'b101,
    L_TX_AK   = 3'b110
  } link_state_t;
endpackage

// ==== src/mask_cmd_if.sv ====
// mask_cmd_if.sv: set and clear commands toward a mask register.
// Assumes one source and one sink on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface mask_cmd_if #(parameter int W = 8);
  logic         set_strb;
  logic         clr_strb;
  logic [W-1:0] bits;
  modport src  (output set_strb, output clr_strb, output bits);
  modport sink (input set_strb, input clr_strb, input bits);
endinterface
`default_nettype wire

// ==== src/pin_sync.sv ====
// pin_sync.sv: two-flop synchroniser for a group of asynchronous pins.
// Assumes the inputs may change at any time relative to i_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(parameter int W = 1) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output var  logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_q    <= '0;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== src/set_clr_mask.sv ====
// set_clr_mask.sv: mask register changed only through set and clear commands.
// Assumes the two strobes never arrive in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module set_clr_mask #(parameter int W = 8) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  mask_cmd_if.sink          cmd,
  output var  logic [W-1:0] o_mask
);
  // Only ones written have an effect, so software needs no read-modify-write.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mask <= '0;
    end else if (cmd.set_strb) begin
      o_mask <= o_mask | cmd.bits;
    end else if (cmd.clr_strb) begin
      o_mask <= o_mask & ~cmd.bits;
    end
  end
endmodule
`default_nettype wire

// ==== src/pmu_twowire_irq_control.sv ====
// pmu_twowire_irq_control.sv: two-wire slave register port, button status and
// interrupt mask, cause and pin logic of the power management unit.
// Assumes all pins are asynchronous to i_clk and the bus runs far below i_clk.
`timescale 1ns/1ps
`default_nettype none
`include "pmu_cfg.svh"
module pmu_twowire_irq_control
  import pmu_pkg::*;
#(
  parameter int SETTLE_NS = `PMU_SELECT_SETTLE_NS,
  parameter int CLK_MHZ   = `PMU_CLK_MHZ
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_bus_clock_pin,
  input  wire logic i_bus_data_pin,
  output var  logic o_bus_data_pin,
  output var  logic o_bus_data_pin_oe_n,
  input  wire logic i_address_select_pin,
  input  wire logic i_interface_select_pin,
  output var  logic o_interface_select_pullup_n,
  output var  logic o_two_wire_selected,
  input  wire logic i_button_pin,
  input  wire logic i_rtc_alarm,
  input  wire logic i_power_fail,
  input  wire logic i_boost_fail,
  input  wire logic i_buck_fail,
  output var  logic o_irq_ready_pin_n
);

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam logic [15:0] SETTLE_CYC = 16'((SETTLE_NS * CLK_MHZ + 999) / 1000);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic [8:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        addr_sel_s;
  logic        if_sel_s;
  logic        button_s;
  logic [3:0]  ext_src_s;
  logic        scl_prev_q;
  logic        sda_prev_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic [15:0] sel_cnt_q;
  logic        sel_done_q;
  link_state_t state_q;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  tx_q;
  logic [7:0]  index_q;
  logic        rw_q;
  logic        first_q;
  logic        ack_on_q;
  logic [7:0]  rx_byte;
  logic [6:0]  own_addr;
  logic        wr_stb;
  logic        tx_load;
  logic [7:0]  rdata;
  logic [7:0]  irq_mask;
  logic [1:0]  bt_mask;
  logic [1:0]  bt_status_q;
  logic [1:0]  bt_clr;
  logic        bt_req;
  logic        bt_req_q;
  logic [3:0]  ext_prev_q;
  logic [4:0]  cause_q;
  logic [4:0]  cause_ev;
  logic        cause_rd;

  mask_cmd_if #(.W(8)) irq_cmd ();
  mask_cmd_if #(.W(2)) bt_cmd ();

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------
  // Reset asserts at once and releases only after two clean edges.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  pin_sync #(.W(9)) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_d     ({i_bus_clock_pin, i_bus_data_pin, i_address_select_pin,
                i_interface_select_pin, i_button_pin, i_buck_fail,
                i_boost_fail, i_power_fail, i_rtc_alarm}),
    .o_q     (pins_s)
  );

  // Bit order of ext_src_s matches the cause bits 4, 3, 2 and 0.
  assign scl_s      = pins_s[8];
  assign sda_s      = pins_s[7];
  assign addr_sel_s = pins_s[6];
  assign if_sel_s   = pins_s[5];
  assign button_s   = pins_s[4];
  assign ext_src_s  = pins_s[3:0];

  // ----------------------------------------------------------------------
  // Interface selection at start-up
  // ----------------------------------------------------------------------
  // The pull-up needs time to charge the pin net before it is sampled.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_cnt_q                   <= 16'h0000;
      sel_done_q                  <= 1'b0;
      o_two_wire_selected         <= 1'b0;
      o_interface_select_pullup_n <= 1'b0;
    end else if (!sel_done_q) begin
      if (sel_cnt_q == SETTLE_CYC) begin
        sel_done_q                  <= 1'b1;
        o_two_wire_selected         <= ~if_sel_s;
        o_interface_select_pullup_n <= 1'b1;
      end else begin
        sel_cnt_q <= sel_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Bus line events
  // ----------------------------------------------------------------------
  // Edges are taken from synchronised copies only; 400 kbps leaves hundreds
  // of cycles per bit, so the added latency costs nothing.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise   = scl_s & ~scl_prev_q;
  assign scl_fall   = ~scl_s & scl_prev_q;
  assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_cond  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign rx_byte    = {shift_q[6:0], sda_s};
  assign own_addr   = addr_sel_s ? `PMU_ADDR_DEFAULT : `PMU_ADDR_ALTERNATE;

  // A read byte is loaded at the end of the address acknowledge, or after
  // the host acknowledged the previous byte.
  assign tx_load = scl_fall & ((state_q == L_ADDR_AK & ack_on_q & rw_q) |
                               (state_q == L_TX_AK));
  assign wr_stb  = (state_q == L_RX) & scl_rise & (bit_cnt_q == 4'h7) & ~first_q;

  // ----------------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------------
  function automatic logic [7:0] reg_read(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      `PMU_IDX_ADDR_READBACK: v = {~addr_sel_s, own_addr};
      `PMU_IDX_BT_STATUS:     v = {6'h00, bt_status_q};
      `PMU_IDX_BT_MASK:       v = {6'h00, bt_mask};
      `PMU_IDX_IRQ_MASK_VIEW: v = irq_mask;
      `PMU_IDX_IRQ_CAUSE:     v = {3'h0, cause_q};
      default:                v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb rdata = reg_read(index_q);

  // ----------------------------------------------------------------------
  // Two-wire slave
  // ----------------------------------------------------------------------
  // The data line changes only just after a falling clock, so it is stable
  // for the whole high phase the host samples in.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q             <= L_IDLE;
      bit_cnt_q           <= 4'h0;
      shift_q             <= 8'h00;
      tx_q                <= 8'h00;
      index_q             <= 8'h00;
      rw_q                <= 1'b0;
      first_q             <= 1'b0;
      ack_on_q            <= 1'b0;
      o_bus_data_pin_oe_n <= 1'b1;
      o_bus_data_pin      <= 1'b0; // Only ever pulls low; the pull-up gives the high level.
    end else if (!o_two_wire_selected) begin
      state_q             <= L_IDLE;
      o_bus_data_pin_oe_n <= 1'b1;
    end else if (start_cond) begin
      state_q             <= L_ADDR;
      bit_cnt_q           <= 4'h0;
      ack_on_q            <= 1'b0;
      o_bus_data_pin_oe_n <= 1'b1;
    end else if (stop_cond) begin
      state_q             <= L_IDLE;
      ack_on_q            <= 1'b0;
      o_bus_data_pin_oe_n <= 1'b1;
    end else if (tx_load) begin
      o_bus_data_pin_oe_n <= rdata[7];
      tx_q                <= {rdata[6:0], 1'b0};
      bit_cnt_q           <= 4'h0;
      ack_on_q            <= 1'b0;
      state_q             <= L_TX;
    end else begin
      unique case (state_q)
        L_ADDR: begin
          if (scl_rise) begin
            shift_q   <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'h7) begin
              rw_q      <= sda_s;
              bit_cnt_q <= 4'h0;
              state_q   <= (shift_q[6:0] == own_addr) ? L_ADDR_AK : L_IDLE;
            end
          end
        end
        L_ADDR_AK, L_RX_AK: begin
          if (scl_fall) begin
            if (!ack_on_q) begin
              o_bus_data_pin_oe_n <= 1'b0;
              ack_on_q            <= 1'b1;
            end else begin
              o_bus_data_pin_oe_n <= 1'b1;
              ack_on_q            <= 1'b0;
              first_q             <= (state_q == L_ADDR_AK);
              state_q <= L_RX;
            end
          end
        end
        L_RX: begin
          if (scl_rise) begin
            shift_q   <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'h7) begin
              bit_cnt_q <= 4'h0;
              first_q   <= 1'b0;
              if (first_q) begin
                index_q <= rx_byte;
              end
              state_q <= L_RX_AK;
            end
          end
        end
        L_TX: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              o_bus_data_pin_oe_n <= 1'b1;
              state_q             <= L_TX_AK;
            end else begin
              o_bus_data_pin_oe_n <= tx_q[7];
              tx_q                <= {tx_q[6:0], 1'b0};
            end
          end
        end
        L_TX_AK: begin
          // A not-acknowledge ends the read; wait quietly for the stop.
          if (scl_rise && sda_s) begin
            state_q <= L_IDLE;
          end
        end
        default: begin
          state_q <= L_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Mask command decode
  // ----------------------------------------------------------------------
  // Command registers are write-only; the written byte goes straight to
  // the mask units. A host that ignores the settle wait may lose nothing
  // here, since every write completes in one cycle.
  always_comb begin
    irq_cmd.set_strb = wr_stb & (index_q == `PMU_IDX_IRQ_ENABLE);
    irq_cmd.clr_strb = wr_stb & (index_q == `PMU_IDX_IRQ_DISABLE);
    irq_cmd.bits     = rx_byte;
    bt_cmd.set_strb  = wr_stb & (index_q == `PMU_IDX_BT_ENABLE);
    bt_cmd.clr_strb  = wr_stb & (index_q == `PMU_IDX_BT_DISABLE);
    bt_cmd.bits      = rx_byte[1:0];
  end

  set_clr_mask #(.W(8)) u_irq_mask (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .cmd     (irq_cmd.sink),
    .o_mask  (irq_mask)
  );

  set_clr_mask #(.W(2)) u_bt_mask (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .cmd     (bt_cmd.sink),
    .o_mask  (bt_mask)
  );

  // ----------------------------------------------------------------------
  // Button status
  // ----------------------------------------------------------------------
  assign bt_clr = (wr_stb && index_q == `PMU_IDX_BT_CLEAR) ? rx_byte[1:0] : 2'h0;

  // The flags follow the level, so a clear while the button still sits at
  // that level has no effect; seeing wins over clearing in the same cycle.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      bt_status_q <= `PMU_BT_RESET;
    end else if (sel_cnt_q > 16'h0001 || sel_done_q) begin // Skip synchroniser reset value.
      bt_status_q[`PMU_BT_BIT_LOW]  <= (bt_status_q[`PMU_BT_BIT_LOW] &
                                        ~bt_clr[`PMU_BT_BIT_LOW]) | ~button_s;
      bt_status_q[`PMU_BT_BIT_HIGH] <= (bt_status_q[`PMU_BT_BIT_HIGH] &
                                        ~bt_clr[`PMU_BT_BIT_HIGH]) | button_s;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt causes and pin
  // ----------------------------------------------------------------------
  assign bt_req   = |(bt_status_q & bt_mask);
  assign cause_ev = {ext_src_s[3:1] & ~ext_prev_q[3:1], bt_req & ~bt_req_q,
                     ext_src_s[0] & ~ext_prev_q[0]};
  assign cause_rd = tx_load & (index_q == `PMU_IDX_IRQ_CAUSE);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev_q <= 4'h0;
      bt_req_q   <= 1'b0;
    end else begin
      ext_prev_q <= ext_src_s;
      bt_req_q   <= bt_req;
    end
  end

  // Reading the causes clears them, but an event in that cycle survives.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_q <= 5'h00;
    end else begin
      cause_q <= (cause_rd ? 5'h00 : cause_q) | cause_ev;
    end
  end

  // The pin falls only for an enabled cause with the global gate open.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_irq_ready_pin_n <= 1'b1;
    end else begin
      o_irq_ready_pin_n <= ~(irq_mask[`PMU_IRQ_BIT_GLOBAL] &
                             (|(cause_q & irq_mask[4:0])));
    end
  end

endmodule
`default_nettype wire

// ==== dv/twowire_irq_monitor.sv ====
// twowire_irq_monitor.sv: pin-level checks of the two-wire slave and irq pin.
// Assumes it is bound into the top module; all pins are sampled on i_clk.
`timescale 1ns/1ps
`default_nettype none
module twowire_irq_monitor (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_bus_clock_pin,
  input wire logic o_bus_data_pin,
  input wire logic o_bus_data_pin_oe_n,
  input wire logic o_interface_select_pullup_n,
  input wire logic o_two_wire_selected,
  input wire logic i_button_pin,
  input wire logic i_rtc_alarm,
  input wire logic i_power_fail,
  input wire logic i_boost_fail,
  input wire logic i_buck_fail,
  input wire logic o_irq_ready_pin_n
);
  // ------------
  // Event ages
  // ------------
  logic [5:0] now;
  logic [5:0] prev_q;
  logic [3:0] fall_q;
  logic [3:0] edge_q;
  logic [3:0] src_q;
  assign now = {i_bus_clock_pin, i_button_pin, i_rtc_alarm, i_power_fail,
                i_boost_fail, i_buck_fail};
  function automatic logic [3:0] age(input logic hit, input logic [3:0] a);
    return hit ? 4'h0 : a + {3'h0, a != 4'hf};
  endfunction
  // Saturating ages; the bounds below leave room for the pin synchronisers.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_q <= 6'h20;
      fall_q <= 4'hf;
      edge_q <= 4'hf;
      src_q  <= 4'hf;
    end else begin
      prev_q <= now;
      fall_q <= age(prev_q[5] & ~now[5], fall_q);
      edge_q <= age(prev_q[5] ^ now[5], edge_q);
      src_q  <= age(|(now[3:0] & ~prev_q[3:0]) | (now[4] ^ prev_q[4]), src_q);
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_drive_high;
    !o_bus_data_pin_oe_n && i_bus_clock_pin;
  endsequence
  sequence s_recent_cause;
    edge_q <= 4'd8 || src_q <= 4'd8;
  endsequence
  a_reset_idle: assert property (
    $rose(i_resetn) |-> o_bus_data_pin_oe_n && o_irq_ready_pin_n
      && !o_two_wire_selected && !o_interface_select_pullup_n)
    else $error("outputs not idle at reset release");
  a_drive_zero: assert property (
    !o_bus_data_pin_oe_n |-> !o_bus_data_pin) else $error("data drive not low");
  a_quiet_unselected: assert property (
    !o_two_wire_selected |-> o_bus_data_pin_oe_n) else $error("bus driven unselected");
  a_select_sticks: assert property (
    o_two_wire_selected |=> o_two_wire_selected) else $error("selection lost");
  a_pullup_off: assert property (
    o_two_wire_selected |-> o_interface_select_pullup_n) else $error("pull-up left on");
  a_change_clock_low: assert property (
    $changed(o_bus_data_pin_oe_n) |-> !i_bus_clock_pin)
    else $error("data changed with bus clock high");
  a_drive_after_fall: assert property (
    $changed(o_bus_data_pin_oe_n) |-> fall_q <= 4'd6)
    else $error("data change not tied to a clock fall");
  a_hold_high: assert property (
    s_drive_high |=> !o_bus_data_pin_oe_n) else $error("drive dropped in high phase");
  a_irq_raise: assert property (
    $fell(o_irq_ready_pin_n) |-> s_recent_cause) else $error("irq pin fell without cause");
  a_irq_release: assert property (
    $rose(o_irq_ready_pin_n) |-> edge_q <= 4'd8) else $error("irq pin rose without access");
endmodule
bind pmu_twowire_irq_control twowire_irq_monitor i_mon (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_bus_clock_pin(i_bus_clock_pin),
  .o_bus_data_pin(o_bus_data_pin), .o_bus_data_pin_oe_n(o_bus_data_pin_oe_n),
  .o_interface_select_pullup_n(o_interface_select_pullup_n),
  .o_two_wire_selected(o_two_wire_selected), .i_button_pin(i_button_pin),
  .i_rtc_alarm(i_rtc_alarm), .i_power_fail(i_power_fail), .i_boost_fail(i_boost_fail),
  .i_buck_fail(i_buck_fail), .o_irq_ready_pin_n(o_irq_ready_pin_n));
`default_nettype wire

// ==== dv/twowire_host.sv ====
// twowire_host.sv: behavioural bus master that reaches the device registers.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module twowire_host #(
  parameter logic [6:0] ADDR = 7'h49,
  parameter int         GAP  = 100
) (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_low
);
  // Target address; the bench moves it together with the select pin.
  logic [6:0] dev_addr = ADDR;
  // ------------
  // Bus phases
  // ------------
  // Clock rests high and data is released between frames.
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // A quarter bit; four make the 160 ns bus clock period.
  task automatic q();
    repeat (10) @(negedge i_clk);
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b0;
    q();
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b0;
    q();
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ak);
    for (int i = 7; i >= 0; i--) begin
      o_sda_low = ~b[i];
      q();
      o_scl = 1'b1;
      q();
      q();
      o_scl = 1'b0;
      q();
    end
    o_sda_low = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    ak = ~i_sda;
    q();
    o_scl = 1'b0;
    q();
  endtask
  // Data is sampled mid high phase; the last byte ends with a not-acknowledge.
  task automatic get_byte(input logic last, output logic [7:0] b);
    o_sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      q();
      o_scl = 1'b1;
      q();
      b[i] = i_sda;
      q();
      o_scl = 1'b0;
      q();
    end
    o_sda_low = ~last;
    q();
    o_scl = 1'b1;
    q();
    q();
    o_scl = 1'b0;
    q();
  endtask
  // The gap is far shorter than three slow-clock periods to keep runs short.
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] d, output logic ak);
    logic a0, a1, a2;
    start();
    put_byte({dev_addr, 1'b0}, a0);
    put_byte(idx, a1);
    put_byte(d, a2);
    stop();
    ak = a0 & a1 & a2;
    repeat (GAP) @(negedge i_clk);
  endtask
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] d, output logic ak);
    logic a0, a1, a2;
    start();
    put_byte({dev_addr, 1'b0}, a0);
    put_byte(idx, a1);
    start();
    put_byte({dev_addr, 1'b1}, a2);
    get_byte(1'b1, d);
    stop();
    ak = a0 & a1 & a2;
  endtask
  task automatic probe(input logic [6:0] a, output logic ak);
    start();
    put_byte({a, 1'b0}, ak);
    stop();
  endtask
endmodule
`default_nettype wire

// ==== dv/pmu_twowire_irq_control_tb.sv ====
// pmu_twowire_irq_control_tb.sv: register and interrupt tests over the bus.
// Assumes twowire_host and the bound monitor are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module pmu_twowire_irq_control_tb;
  // ------------
  // Bench
  // ------------
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       btn = 1'b1;
  logic       asel = 1'b1;
  logic [4:0] src = 5'h00;
  logic       scl, sda_low, sda, dout, oe_n, pu_n, sel, irq_n;
  int         miscompares = 0;
  int         checks_done = 0;
  int         cycles = 0;
  // Open-drain wire: pulled up unless either party pulls it low.
  assign sda = (oe_n ? 1'b1 : dout) & ~sda_low;
  always #2 clk = ~clk;
  pmu_twowire_irq_control #(.SETTLE_NS(20)) i_dut (
    .i_clk(clk), .i_resetn(resetn), .i_bus_clock_pin(scl), .i_bus_data_pin(sda),
    .o_bus_data_pin(dout), .o_bus_data_pin_oe_n(oe_n), .i_address_select_pin(asel),
    .i_interface_select_pin(1'b0), .o_interface_select_pullup_n(pu_n),
    .o_two_wire_selected(sel), .i_button_pin(btn), .i_rtc_alarm(src[0]),
    .i_power_fail(src[2]), .i_boost_fail(src[3]), .i_buck_fail(src[4]),
    .o_irq_ready_pin_n(irq_n));
  twowire_host #(.GAP(100)) i_host (
    .i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic ak;
    i_host.write_reg(idx, d, ak);
    chk("write ack", 8'h01, {7'h00, ak});
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic       ak;
    i_host.read_reg(idx, d, ak);
    chk("read ack", 8'h01, {7'h00, ak});
    chk($sformatf("register %h", idx), exp, d);
  endtask
  task automatic pin(input logic exp);
    repeat (10) @(negedge clk);
    chk("irq pin", {7'h00, exp}, {7'h00, irq_n});
  endtask
  task automatic wait_sel();
    for (int i = 0; i < 400 && sel !== 1'b1; i++) @(negedge clk);
    chk("selected", 8'h01, {7'h00, sel});
    chk("pull-up off", 8'h01, {7'h00, pu_n});
  endtask
  // A hang ends the run as a failure.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    logic       ak;
    logic [7:0] t [4][3];
    int         k [3];
    t = '{'{8'h08, 8'h05, 8'h05}, '{8'h08, 8'h00, 8'h05}, '{8'h08, 8'h80, 8'h85},
          '{8'h09, 8'h01, 8'h84}};
    k = '{3, 4, 0};
    repeat (16) @(negedge clk);
    chk("irq pin in reset", 8'h01, {7'h00, irq_n});
    resetn = 1'b1;
    wait_sel();
    rd(8'h01, 8'h49);
    rd(8'h0a, 8'h00);
    rd(8'h06, 8'h00);
    i_host.probe(7'h48, ak);
    chk("foreign ack", 8'h00, {7'h00, ak});
    // Set and clear writes walk the mask like the masking example.
    for (int i = 0; i < 4; i++) begin
      wr(t[i][0], t[i][1]);
      rd(8'h0a, t[i][2]);
    end
    src[0] = 1'b1;
    pin(1'b1);
    src[2] = 1'b1;
    pin(1'b0);
    rd(8'h0b, 8'h05);
    pin(1'b1);
    src = 5'h00;
    wr(8'h08, 8'h1f);
    foreach (k[i]) begin
      src[k[i]] = 1'b1;
      pin(1'b0);
      rd(8'h0b, 8'h01 << k[i]);
      pin(1'b1);
      src[k[i]] = 1'b0;
    end
    wr(8'h09, 8'h80);
    src[3] = 1'b1;
    pin(1'b1);
    rd(8'h0b, 8'h08);
    src[3] = 1'b0;
    wr(8'h08, 8'h80);
    rd(8'h02, 8'h02);
    btn = 1'b0;
    rd(8'h02, 8'h03);
    wr(8'h03, 8'h02);
    rd(8'h02, 8'h01);
    wr(8'h03, 8'h00);
    rd(8'h02, 8'h01);
    wr(8'h04, 8'h02);
    rd(8'h06, 8'h02);
    btn = 1'b1;
    pin(1'b0);
    rd(8'h0b, 8'h02);
    wr(8'h05, 8'h00);
    rd(8'h06, 8'h02);
    wr(8'h05, 8'h02);
    rd(8'h06, 8'h00);
    rd(8'h0c, 8'h00);
    resetn = 1'b0;
    asel = 1'b0;
    i_host.dev_addr = 7'h48;
    repeat (4) @(negedge clk);
    chk("drive in reset", 8'h01, {7'h00, oe_n});
    resetn = 1'b1;
    wait_sel();
    rd(8'h01, 8'hc8);
    i_host.probe(7'h49, ak);
    chk("foreign ack", 8'h00, {7'h00, ak});
    rd(8'h0a, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
